/* File: mrd_defs.svh */
`ifndef MRD_DEFS_SVH
`define MRD_DEFS_SVH

// Instruction cycle length in clocks.
`define MRD_OSC_PER_CYCLE 3'h4

// Register byte addresses.
`define MRD_ADDR_CTRL 12'h000
`define MRD_ADDR_INSTR 12'h004
`define MRD_ADDR_ACC 12'h008
`define MRD_ADDR_STATUS 12'h00c
`define MRD_ADDR_PC 12'h010
`define MRD_ADDR_FILE 12'h200

// Status field positions.
`define MRD_ST_C 0
`define MRD_ST_HC 1
`define MRD_ST_Z 2
`define MRD_ST_SLP 3
`define MRD_ST_WDX 4
`define MRD_ST_BUSY 5
`define MRD_ST_SKIP 6

// Control field positions.
`define MRD_CTRL_PSA_T0 0
`define MRD_CTRL_PSC_CLR 1

// Special file register addresses.
`define MRD_F_TIMER0 7'h01
`define MRD_F_PORTA 7'h05
`define MRD_F_PORTB 7'h06

// Reset values.
`define MRD_RST_STATUS 8'h18
`define MRD_RST_CTRL 8'h01

// Fixed standby word.
`define MRD_WORD_STANDBY 14'h0063

`endif

/* File: mrd_pkg.sv */
package mrd_pkg;

    typedef enum logic [4:0] {
        ALU_NONE = 5'h00,
        ALU_ADDWF = 5'h01,
        ALU_ANDWF = 5'h02,
        ALU_CLR = 5'h03,
        ALU_COMF = 5'h04,
        ALU_DECF = 5'h05,
        ALU_DECSZ = 5'h06,
        ALU_INCF = 5'h07,
        ALU_INCSZ = 5'h08,
        ALU_ORF = 5'h09,
        ALU_MOVF = 5'h0a,
        ALU_MOVWF = 5'h0b,
        ALU_ROTL = 5'h0c,
        ALU_ROTR = 5'h0d,
        ALU_SUBWF = 5'h0e,
        ALU_SWAPF = 5'h0f,
        ALU_XORF = 5'h10,
        ALU_BCF = 5'h11,
        ALU_BSF = 5'h12,
        ALU_BTSC = 5'h13,
        ALU_BTSS = 5'h14,
        ALU_ADDLW = 5'h15,
        ALU_ANDLW = 5'h16,
        ALU_ORL = 5'h17,
        ALU_XORL = 5'h18,
        ALU_MOVLW = 5'h19,
        ALU_LSUB = 5'h1a,
        ALU_RETL = 5'h1b,
        ALU_RETURN = 5'h1c,
        ALU_CALL = 5'h1d,
        ALU_GOTO = 5'h1e,
        ALU_SYS = 5'h1f
    } mrd_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_FLUSH = 2'b10
    } mrd_state_e;

endpackage

/* File: mrd_adder.sv */
`timescale 1ns/1ps

// Eight-bit adder with carry and digit carry; subtraction adds the complement plus one.
module mrd_adder (
    // Operands.
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic sub,
    // Result.
    output logic [7:0] sum,
    output logic carry,
    output logic half_carry
);
    logic [7:0] bx;
    logic [4:0] lo;
    logic [8:0] full;

    assign bx = sub ? ~b : b;
    assign lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub};
    assign full = {1'b0, a} + {1'b0, bx} + {8'h00, sub};
    assign sum = full[7:0];
    assign carry = full[8];
    assign half_carry = lo[4];
endmodule

/* File: mrd_core.sv */
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "mrd_defs.svh"

module mrd_core #(
    parameter int FILE_DEPTH = 128,
    parameter int STACK_DEPTH = 8
) (
    // Clock, enable and reset.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins.
    input wire logic [7:0] porta_pins,
    input wire logic [7:0] portb_pins,
    // Core state.
    output logic [10:0] pc_out,
    output logic standby,
    output logic prescaler_clear
);
    mrd_pkg::mrd_op_e op;
    mrd_pkg::mrd_state_e state_q;
    logic [13:0] instr_q;
    logic [7:0] acc_q;
    logic [7:0] status_q;
    logic [7:0] ctrl_q;
    logic [10:0] pc_q;
    logic [7:0] file_q [FILE_DEPTH];
    logic [10:0] stack_q [STACK_DEPTH];
    logic [2:0] sp_q;
    logic [2:0] phase_q;
    logic [7:0] prdata_q;
    logic skip_q;
    logic [6:0] faddr;
    logic [2:0] bidx;
    logic [7:0] lit;
    logic dsel;
    logic [7:0] fval;
    logic [7:0] res;
    logic wr_acc;
    logic wr_file;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic new_c;
    logic take2;
    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_sub;
    logic [7:0] add_sum;
    logic add_c;
    logic add_dc;
    logic apb_wr;
    logic apb_rd;
    logic step;
    logic exec_go;

    assign faddr = instr_q[6:0];
    assign bidx = instr_q[9:7];
    assign lit = instr_q[7:0];
    assign dsel = instr_q[7];

    // Decode; x positions are left out of every compare.
    always_comb begin
        op = mrd_pkg::ALU_NONE;
        unique casez (instr_q)
            14'b00_0111_????_????: op = mrd_pkg::ALU_ADDWF;
            14'b00_0101_????_????: op = mrd_pkg::ALU_ANDWF;
            14'b00_0001_????_????: op = mrd_pkg::ALU_CLR;
            14'b00_1001_????_????: op = mrd_pkg::ALU_COMF;
            14'b00_0011_????_????: op = mrd_pkg::ALU_DECF;
            14'b00_1011_????_????: op = mrd_pkg::ALU_DECSZ;
            14'b00_1010_????_????: op = mrd_pkg::ALU_INCF;
            14'b00_1111_????_????: op = mrd_pkg::ALU_INCSZ;
            14'b00_0100_????_????: op = mrd_pkg::ALU_ORF;
            14'b00_1000_????_????: op = mrd_pkg::ALU_MOVF;
            14'b00_0000_1???_????: op = mrd_pkg::ALU_MOVWF;
            14'b00_1101_????_????: op = mrd_pkg::ALU_ROTL;
            14'b00_1100_????_????: op = mrd_pkg::ALU_ROTR;
            14'b00_0010_????_????: op = mrd_pkg::ALU_SUBWF;
            14'b00_1110_????_????: op = mrd_pkg::ALU_SWAPF;
            14'b00_0110_????_????: op = mrd_pkg::ALU_XORF;
            14'b01_00??_????_????: op = mrd_pkg::ALU_BCF;
            14'b01_01??_????_????: op = mrd_pkg::ALU_BSF;
            14'b01_10??_????_????: op = mrd_pkg::ALU_BTSC;
            14'b01_11??_????_????: op = mrd_pkg::ALU_BTSS;
            14'b11_111?_????_????: op = mrd_pkg::ALU_ADDLW;
            14'b11_1001_????_????: op = mrd_pkg::ALU_ANDLW;
            14'b11_1000_????_????: op = mrd_pkg::ALU_ORL;
            14'b11_1010_????_????: op = mrd_pkg::ALU_XORL;
            14'b11_00??_????_????: op = mrd_pkg::ALU_MOVLW;
            14'b11_110?_????_????: op = mrd_pkg::ALU_LSUB;
            14'b11_01??_????_????: op = mrd_pkg::ALU_RETL;
            14'b10_0???_????_????: op = mrd_pkg::ALU_CALL;
            14'b10_1???_????_????: op = mrd_pkg::ALU_GOTO;
            14'b00_0000_0000_1000: op = mrd_pkg::ALU_RETURN;
            14'b00_0000_0000_1001: op = mrd_pkg::ALU_RETURN;
            14'b00_0000_0110_0011: op = mrd_pkg::ALU_SYS;
            14'b00_0000_0110_0100: op = mrd_pkg::ALU_SYS;
            default: op = mrd_pkg::ALU_NONE;
        endcase
    end

    // Instruction reads of the port registers return the pin levels.
    always_comb begin
        if (faddr == `MRD_F_PORTA) begin
            fval = porta_pins;
        end else if (faddr == `MRD_F_PORTB) begin
            fval = portb_pins;
        end else begin
            fval = file_q[faddr];
        end
    end

    always_comb begin
        add_a = fval;
        add_b = acc_q;
        add_sub = 1'b0;
        unique case (op)
            mrd_pkg::ALU_SUBWF: add_sub = 1'b1;
            mrd_pkg::ALU_ADDLW: add_a = lit;
            mrd_pkg::ALU_LSUB: begin
                add_a = lit;
                add_sub = 1'b1;
            end
            mrd_pkg::ALU_DECF, mrd_pkg::ALU_DECSZ: begin
                add_b = 8'h01;
                add_sub = 1'b1;
            end
            mrd_pkg::ALU_INCF, mrd_pkg::ALU_INCSZ: add_b = 8'h01;
            default: add_sub = 1'b0;
        endcase
    end

    mrd_adder u_adder (
        .a(add_a),
        .b(add_b),
        .sub(add_sub),
        .sum(add_sum),
        .carry(add_c),
        .half_carry(add_dc)
    );

    always_comb begin
        res = 8'h00;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        new_c = add_c;
        take2 = 1'b0;
        unique case (op)
            mrd_pkg::ALU_ADDWF, mrd_pkg::ALU_SUBWF: begin
                res = add_sum;
                {upd_z, upd_c, upd_dc} = 3'h7;
            end
            mrd_pkg::ALU_ANDWF: begin
                res = acc_q & fval;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_CLR: begin
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_COMF: begin
                res = ~fval;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_DECF, mrd_pkg::ALU_INCF: begin
                res = add_sum;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_DECSZ, mrd_pkg::ALU_INCSZ: begin
                res = add_sum;
                take2 = (add_sum == 8'h00);
            end
            mrd_pkg::ALU_ORF: begin
                res = acc_q | fval;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_XORF: begin
                res = acc_q ^ fval;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_MOVF: begin
                res = fval;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_MOVWF: begin
                res = acc_q;
                wr_file = 1'b1;
            end
            mrd_pkg::ALU_ROTL: begin
                res = {fval[6:0], status_q[`MRD_ST_C]};
                new_c = fval[7];
                upd_c = 1'b1;
            end
            mrd_pkg::ALU_ROTR: begin
                res = {status_q[`MRD_ST_C], fval[7:1]};
                new_c = fval[0];
                upd_c = 1'b1;
            end
            mrd_pkg::ALU_SWAPF: res = {fval[3:0], fval[7:4]};
            mrd_pkg::ALU_BCF: begin
                res = fval & ~(8'h01 << bidx);
                wr_file = 1'b1;
            end
            mrd_pkg::ALU_BSF: begin
                res = fval | (8'h01 << bidx);
                wr_file = 1'b1;
            end
            mrd_pkg::ALU_BTSC: take2 = ~fval[bidx];
            mrd_pkg::ALU_BTSS: take2 = fval[bidx];
            mrd_pkg::ALU_ADDLW, mrd_pkg::ALU_LSUB: begin
                res = add_sum;
                wr_acc = 1'b1;
                {upd_z, upd_c, upd_dc} = 3'h7;
            end
            mrd_pkg::ALU_ANDLW: begin
                res = acc_q & lit;
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_ORL: begin
                res = acc_q | lit;
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_XORL: begin
                res = acc_q ^ lit;
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            mrd_pkg::ALU_MOVLW: begin
                res = lit;
                wr_acc = 1'b1;
            end
            mrd_pkg::ALU_RETL: begin
                res = lit;
                wr_acc = 1'b1;
                take2 = 1'b1;
            end
            mrd_pkg::ALU_RETURN, mrd_pkg::ALU_CALL, mrd_pkg::ALU_GOTO: take2 = 1'b1;
            default: take2 = 1'b0;
        endcase
        if (op inside {mrd_pkg::ALU_ADDWF, mrd_pkg::ALU_SUBWF, mrd_pkg::ALU_ANDWF, mrd_pkg::ALU_CLR,
                mrd_pkg::ALU_COMF, mrd_pkg::ALU_DECF, mrd_pkg::ALU_DECSZ, mrd_pkg::ALU_INCF, mrd_pkg::ALU_INCSZ,
                mrd_pkg::ALU_ORF, mrd_pkg::ALU_XORF, mrd_pkg::ALU_MOVF, mrd_pkg::ALU_ROTL, mrd_pkg::ALU_ROTR,
                mrd_pkg::ALU_SWAPF}) begin
            wr_file = dsel;
            wr_acc = ~dsel;
        end
    end

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = {24'h000000, prdata_q};
    assign step = clk_en && (phase_q == `MRD_OSC_PER_CYCLE - 3'h1);
    assign exec_go = step && (state_q == mrd_pkg::ST_EXEC);
    assign pc_out = pc_q;
    assign standby = status_q[`MRD_ST_SLP] == 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 3'h0;
        end else if (clk_en) begin
            phase_q <= step ? 3'h0 : phase_q + 3'h1;
        end
    end

    // Instruction cycle sequencer; a taken branch or skip adds a flush cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= mrd_pkg::ST_IDLE;
        end else if (clk_en) begin
            if (apb_wr && paddr == `MRD_ADDR_INSTR && state_q == mrd_pkg::ST_IDLE && !standby) begin
                state_q <= mrd_pkg::ST_EXEC;
            end else if (step && state_q == mrd_pkg::ST_EXEC) begin
                state_q <= take2 ? mrd_pkg::ST_FLUSH : mrd_pkg::ST_IDLE;
            end else if (step && state_q == mrd_pkg::ST_FLUSH) begin
                state_q <= mrd_pkg::ST_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= 14'h0000;
        end else if (clk_en && apb_wr && paddr == `MRD_ADDR_INSTR && state_q == mrd_pkg::ST_IDLE) begin
            instr_q <= pwdata[13:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 8'h00;
        end else if (clk_en) begin
            if (exec_go && wr_acc) begin
                acc_q <= res;
            end else if (apb_wr && paddr == `MRD_ADDR_ACC && state_q == mrd_pkg::ST_IDLE) begin
                acc_q <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (clk_en) begin
            if (exec_go && wr_file) begin
                file_q[faddr] <= res;
            end else if (apb_wr && paddr[11:9] == 3'h1 && state_q == mrd_pkg::ST_IDLE) begin
                file_q[paddr[8:2]] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `MRD_RST_STATUS;
        end else if (clk_en) begin
            if (exec_go) begin
                status_q[`MRD_ST_SKIP] <= take2;
                if (upd_z) begin
                    status_q[`MRD_ST_Z] <= (res == 8'h00);
                end
                if (upd_c) begin
                    status_q[`MRD_ST_C] <= new_c;
                end
                if (upd_dc) begin
                    status_q[`MRD_ST_HC] <= add_dc;
                end
                if (op == mrd_pkg::ALU_SYS) begin
                    status_q[`MRD_ST_WDX] <= 1'b1;
                    status_q[`MRD_ST_SLP] <= (instr_q != `MRD_WORD_STANDBY);
                end
            end else if (apb_wr && paddr == `MRD_ADDR_STATUS) begin
                status_q[4:0] <= pwdata[4:0];
            end
            status_q[`MRD_ST_BUSY] <= (state_q != mrd_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= 11'h000;
            sp_q <= 3'h0;
        end else if (exec_go) begin
            unique case (op)
                mrd_pkg::ALU_GOTO: pc_q <= instr_q[10:0];
                mrd_pkg::ALU_CALL: begin
                    stack_q[sp_q] <= pc_q + 11'h001;
                    sp_q <= sp_q + 3'h1;
                    pc_q <= instr_q[10:0];
                end
                mrd_pkg::ALU_RETURN, mrd_pkg::ALU_RETL: begin
                    pc_q <= stack_q[sp_q - 3'h1];
                    sp_q <= sp_q - 3'h1;
                end
                default: pc_q <= pc_q + (take2 ? 11'h002 : 11'h001);
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `MRD_RST_CTRL;
        end else if (clk_en && apb_wr && paddr == `MRD_ADDR_CTRL) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    // One-clock pulse when an instruction writes the timer zero count register while MRD_CTRL_PSA_T0 is set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler_clear <= 1'b0;
        end else if (clk_en) begin
            prescaler_clear <= exec_go && wr_file && faddr == `MRD_F_TIMER0
                && ctrl_q[`MRD_CTRL_PSA_T0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 8'h00;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `MRD_ADDR_CTRL) begin
                prdata_q <= ctrl_q;
            end else if (paddr == `MRD_ADDR_ACC) begin
                prdata_q <= acc_q;
            end else if (paddr == `MRD_ADDR_STATUS) begin
                prdata_q <= status_q;
            end else if (paddr == `MRD_ADDR_PC) begin
                prdata_q <= pc_q[7:0];
            end else if (paddr[11:9] == 3'h1) begin
                prdata_q <= file_q[paddr[8:2]];
            end else begin
                prdata_q <= 8'h00;
            end
        end
    end
endmodule

/* File: mrd_core_monitor.sv */
`timescale 1ns/1ps
`include "mrd_defs.svh"

module mrd_core_monitor (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB request.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Core state.
    input wire logic [10:0] pc_out,
    input wire logic standby,
    input wire logic prescaler_clear
);
    logic [3:0] cnt_q;
    logic [13:0] ins_q;
    logic [10:0] pc0_q;
    logic wr_ins;
    assign wr_ins = clk_en && psel && penable && pwrite && paddr == 12'h004;
    // Counts clocks since the last instruction word was handed over.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'hf;
            ins_q <= 14'h0000;
            pc0_q <= 11'h000;
        end else if (wr_ins) begin
            cnt_q <= 4'h0;
            ins_q <= pwdata[13:0];
            pc0_q <= pc_out;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    a_plain_step: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q == 4'h7 && ins_q[13:12] == 2'b11 && ins_q[11:10] != 2'b01 |-> pc_out == pc0_q + 11'h001)
        else $error("literal operation did not advance the counter by one");
    a_skip_step: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q == 4'hc && (ins_q[13:8] == 6'h0b || ins_q[13:8] == 6'h0f || ins_q[13:11] == 3'b011)
        |-> pc_out == pc0_q + 11'h001 || pc_out == pc0_q + 11'h002)
        else $error("skip operation moved the counter by neither one nor two");
    a_jump_target: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q == 4'hc && ins_q[13:12] == 2'b10 |-> pc_out == ins_q[10:0])
        else $error("jump did not load the eleven bit target");
    a_standby_enter: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q == 4'hc && ins_q == `MRD_WORD_STANDBY |-> standby)
        else $error("standby word did not enter standby");
    a_standby_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(standby) |-> ins_q == `MRD_WORD_STANDBY && cnt_q <= 4'h6)
        else $error("standby entered without the standby word");
    a_psc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        prescaler_clear |=> !prescaler_clear)
        else $error("prescaler clear longer than one clock");
    a_psc_cause: assert property (@(posedge pclk) disable iff (!presetn)
        prescaler_clear |-> ins_q[6:0] == `MRD_F_TIMER0 && cnt_q <= 4'h6)
        else $error("prescaler cleared by an unrelated instruction");
    a_pc_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(pc_out) |-> cnt_q >= 4'h1 && cnt_q <= 4'hb)
        else $error("counter moved outside an instruction cycle");
endmodule

bind mrd_core mrd_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pc_out(pc_out),
    .standby(standby), .prescaler_clear(prescaler_clear));

/* File: mrd_prog_mem.sv */
`timescale 1ns/1ps

module mrd_prog_mem (
    // Clock and loading.
    input wire logic pclk,
    input wire logic load_en,
    input wire logic [10:0] load_addr,
    input wire logic [13:0] load_word,
    // Fetch.
    input wire logic [10:0] fetch_addr,
    output logic [13:0] fetch_word
);
    logic [13:0] mem_q [0:2047];
    // Empty words read as no-operation.
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem_q[i] = 14'h0000;
        end
    end
    always @(posedge pclk) begin
        if (load_en) begin
            mem_q[load_addr] <= load_word;
        end
    end
    assign fetch_word = mem_q[fetch_addr];
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] porta_pins = 8'h00;
    logic [7:0] portb_pins = 8'h00;
    logic [10:0] pc_out;
    logic standby;
    logic prescaler_clear;
    logic ld_en = 1'b0;
    logic [10:0] ld_addr = 11'h000;
    logic [13:0] ld_word = 14'h0000;
    logic [13:0] fetch_word;
    int err_total = 0;
    int checked = 0;
    int psc_seen = 0;

    mrd_core dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .porta_pins(porta_pins), .portb_pins(portb_pins), .pc_out(pc_out),
        .standby(standby), .prescaler_clear(prescaler_clear));
    mrd_prog_mem u_mem (.pclk(pclk), .load_en(ld_en), .load_addr(ld_addr), .load_word(ld_word),
        .fetch_addr(pc_out), .fetch_word(fetch_word));

    initial begin
        forever #4 pclk = ~pclk;
    end
    always @(negedge pclk) begin
        if (prescaler_clear === 1'b1) begin
            psc_seen++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q & m, exp);
    endtask
    task automatic run(input logic [13:0] w);
        logic [31:0] q;
        apb(1'b1, 12'h004, {18'h0, w}, q);
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, 12'h00c, 32'h0, q);
            if (q[5] === 1'b0) break;
        end
        chk({31'h0, q[5]}, 32'h0);
    endtask
    task automatic chk_pc(input logic [10:0] exp);
        chk({21'h0, pc_out}, {21'h0, exp});
    endtask
    task automatic ld(input logic [10:0] a, input logic [13:0] w);
        @(posedge pclk);
        ld_en <= 1'b1;
        ld_addr <= a;
        ld_word <= w;
        @(posedge pclk);
        ld_en <= 1'b0;
    endtask

    task automatic t_reset();
        logic [31:0] q;
        rdm(12'h00c, 32'hff, 32'h18);
        rdm(12'h000, 32'hff, 32'h01);
        rdm(12'h100, 32'hffffffff, 32'h0);
        apb(1'b1, 12'h100, 32'h5a, q);
        rdm(12'h100, 32'hffffffff, 32'h0);
        chk({31'h0, pslverr}, 32'h0);
        chk_pc(11'h000);
        chk({31'h0, standby}, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_literal();
        run(14'h303c);
        run(14'h38c3);
        rdm(12'h008, 32'hff, 32'hff);
        rdm(12'h00c, 32'h04, 32'h00);
        run(14'h3aff);
        rdm(12'h008, 32'hff, 32'h00);
        rdm(12'h00c, 32'h04, 32'h04);
        run(14'h3005);
        run(14'h3c03);
        rdm(12'h008, 32'hff, 32'hfe);
        rdm(12'h00c, 32'h07, 32'h00);
        run(14'h3005);
        run(14'h3d05);
        rdm(12'h008, 32'hff, 32'h00);
        rdm(12'h00c, 32'h07, 32'h07);
        $display("literal test done");
    endtask
    task automatic t_file();
        logic [10:0] p;
        run(14'h3001);
        run(14'h00a0);
        p = pc_out;
        run(14'h0ba0);
        chk_pc(p + 11'h2);
        rdm(12'h00c, 32'h40, 32'h40);
        rdm(12'h280, 32'hff, 32'h00);
        p = pc_out;
        run(14'h0f20);
        chk_pc(p + 11'h1);
        rdm(12'h008, 32'hff, 32'h01);
        rdm(12'h280, 32'hff, 32'h00);
        run(14'h3041);
        run(14'h00a1);
        run(14'h0da1);
        rdm(12'h284, 32'hff, 32'h83);
        rdm(12'h00c, 32'h07, 32'h06);
        run(14'h0c21);
        rdm(12'h008, 32'hff, 32'h41);
        rdm(12'h00c, 32'h07, 32'h07);
        run(14'h0421);
        rdm(12'h008, 32'hff, 32'hc3);
        rdm(12'h00c, 32'h04, 32'h00);
        run(14'h00a1);
        run(14'h06a1);
        rdm(12'h284, 32'hff, 32'h00);
        rdm(12'h008, 32'hff, 32'hc3);
        rdm(12'h00c, 32'h04, 32'h04);
        $display("file test done");
    endtask
    task automatic t_bits();
        logic [13:0] w [4] = '{14'h1822, 14'h1ba2, 14'h1c22, 14'h1ca2};
        logic [10:0] s [4] = '{11'h1, 11'h2, 11'h2, 11'h1};
        logic [10:0] p;
        run(14'h3001);
        run(14'h00a2);
        for (int i = 0; i < 4; i++) begin
            p = pc_out;
            run(w[i]);
            chk_pc(p + s[i]);
        end
        $display("bit test done");
    endtask
    task automatic t_branch();
        ld(pc_out, 14'h2923);
        ld(11'h123, 14'h2050);
        ld(11'h050, 14'h375a);
        run(fetch_word);
        chk_pc(11'h123);
        run(fetch_word);
        chk_pc(11'h050);
        run(fetch_word);
        chk_pc(11'h124);
        rdm(12'h008, 32'hff, 32'h5a);
        rdm(12'h010, 32'hff, 32'h24);
        $display("branch test done");
    endtask
    task automatic t_port_timer();
        logic [31:0] q;
        porta_pins <= 8'ha5;
        portb_pins <= 8'h0f;
        run(14'h0806);
        rdm(12'h008, 32'hff, 32'h0f);
        run(14'h0805);
        rdm(12'h008, 32'hff, 32'ha5);
        psc_seen = 0;
        run(14'h0181);
        chk(psc_seen, 1);
        run(14'h0801);
        chk(psc_seen, 1);
        apb(1'b1, 12'h000, 32'h0, q);
        run(14'h0181);
        chk(psc_seen, 1);
        $display("port and timer test done");
    endtask
    task automatic t_standby();
        run(14'h0063);
        chk({31'h0, standby}, 32'h1);
        rdm(12'h00c, 32'h18, 32'h10);
        $display("standby test done");
    endtask

    task automatic end_sim();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_literal();
        t_file();
        t_bits();
        t_branch();
        t_port_timer();
        t_standby();
        end_sim();
    end
endmodule
